/* File: core/bce_pkg.sv */
package bce_pkg;
  localparam int BCE_SEL_MSB = 7;
  localparam int BCE_SEL_LSB = 4;
  localparam int BCE_OPC_W = 8;

  localparam logic [31:0] BCE_REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] BCE_REG_FLAGS = 32'h0000_0004;
  localparam logic [31:0] BCE_REG_OPCODE = 32'h0000_0008;
  localparam logic [31:0] BCE_REG_RESULT = 32'h0000_000C;
  localparam logic [31:0] BCE_REG_COUNT = 32'h0000_0010;

  localparam int BCE_CTRL_REG_EN = 0;
  localparam int BCE_CTRL_INV = 1;
  localparam logic [1:0] BCE_CTRL_RST = 2'h0;

  localparam int BCE_FLAG_C = 0;
  localparam int BCE_FLAG_Z = 1;
  localparam int BCE_FLAG_S = 2;
  localparam int BCE_FLAG_V = 3;
  localparam logic [3:0] BCE_FLAGS_RST = 4'h0;
  localparam logic [7:0] BCE_OPC_RST = 8'h00;

  localparam int BCE_RES_TAKEN = 0;
  localparam int BCE_RES_VALID = 1;
  localparam int BCE_RES_SEL_LSB = 4;

  localparam logic [1:0] BCE_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] BCE_HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    BCE_TEST_NEVER = 3'b000,
    BCE_TEST_SLT = 3'b001,
    BCE_TEST_SLE = 3'b010,
    BCE_TEST_ULE = 3'b011,
    BCE_TEST_OV = 3'b100,
    BCE_TEST_NEG = 3'b101,
    BCE_TEST_ZERO = 3'b110,
    BCE_TEST_CARRY = 3'b111
  } bce_test_t;
endpackage

/* File: core/bce_cond_eval.sv */
`timescale 1ns/10ps
module bce_cond_eval
  import bce_pkg::*;
(
  input wire logic [3:0] branch_condition_selector,
  input wire logic flag_c,
  input wire logic flag_z,
  input wire logic flag_s,
  input wire logic flag_v,
  output logic take
);
  wire logic s_xor_v;
  wire logic invert;
  logic base;
  bce_test_t test;

  assign s_xor_v = flag_s ^ flag_v;
  assign invert = branch_condition_selector[3];
  assign test = bce_test_t'(branch_condition_selector[2:0]);

  always_comb begin
    unique case (test)
      BCE_TEST_NEVER: base = 1'b0;
      BCE_TEST_SLT: base = s_xor_v;
      BCE_TEST_SLE: base = flag_z | s_xor_v;
      BCE_TEST_ULE: base = flag_c | flag_z;
      BCE_TEST_OV: base = flag_v;
      BCE_TEST_NEG: base = flag_s;
      BCE_TEST_ZERO: base = flag_z;
      BCE_TEST_CARRY: base = flag_c;
    endcase
  end

  assign take = base ^ invert;
endmodule // bce_cond_eval

/* File: core/bce_branch_eval.sv */
`timescale 1ns/10ps
// Contract
// - selector is four bits, taken from opcode bits seven to four.
// - branch only when test true; 0000 never, 1000 always.
// - only C, Z, S, V decide; both absolute and relative forms.
// - 0001 is S xor V; 0010 is Z or that; 1001, 1010 complements.
// - 0011 true on C or Z; 1011 true when both clear.
// - 0111 true when carry set; 1111 true when carry clear.
// - 0100/0101/0110 test V/S/Z set; 1100/1101/1110 test clear.
module bce_branch_eval
  import bce_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] opcode,
  input wire logic opcode_valid,
  input wire logic conditional_absolute_jump,
  input wire logic conditional_relative_jump,
  input wire logic flag_c,
  input wire logic flag_z,
  input wire logic flag_s,
  input wire logic flag_v,
  output logic branch_taken,
  output logic branch_valid,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  logic [1:0] ctrl;
  logic [3:0] sw_flags;
  logic [7:0] sw_opcode;
  logic [15:0] taken_count;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic sw_taken_q;
  logic [31:0] next_hrdata;

  wire logic [3:0] core_sel;
  wire logic [3:0] sw_sel;
  wire logic is_cond_jump;
  wire logic core_take;
  wire logic sw_take;
  wire logic addr_phase;
  wire logic rd_phase;
  wire logic wr_ctrl;
  wire logic wr_flags;
  wire logic wr_opcode;
  wire logic wr_count;

  assign core_sel = opcode[BCE_SEL_MSB:BCE_SEL_LSB];
  assign sw_sel = sw_opcode[BCE_SEL_MSB:BCE_SEL_LSB];
  // both jump forms share one evaluator
  assign is_cond_jump = opcode_valid &
    (conditional_absolute_jump | conditional_relative_jump);

  bce_cond_eval u_core_eval (
    .branch_condition_selector(core_sel),
    .flag_c(flag_c),
    .flag_z(flag_z),
    .flag_s(flag_s),
    .flag_v(flag_v),
    .take(core_take)
  );

  bce_cond_eval u_sw_eval (
    .branch_condition_selector(sw_sel),
    .flag_c(sw_flags[BCE_FLAG_C]),
    .flag_z(sw_flags[BCE_FLAG_Z]),
    .flag_s(sw_flags[BCE_FLAG_S]),
    .flag_v(sw_flags[BCE_FLAG_V]),
    .take(sw_take)
  );

  // registered decision toward pc sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      branch_taken <= 1'b0;
      branch_valid <= 1'b0;
    end else begin
      branch_valid <= is_cond_jump;
      branch_taken <= is_cond_jump & core_take;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      taken_count <= 16'h0000;
    end else if (wr_count) begin
      taken_count <= 16'h0000;
    end else if (is_cond_jump && core_take && ctrl[BCE_CTRL_REG_EN]) begin
      taken_count <= taken_count + 16'h0001;
    end
  end

  // ahb-lite slave, zero wait states
  assign addr_phase = hsel & hready & htrans[1];
  assign rd_phase = addr_phase & ~hwrite;
  assign wr_ctrl = wr_pend & (wr_addr == BCE_REG_CTRL);
  assign wr_flags = wr_pend & (wr_addr == BCE_REG_FLAGS);
  assign wr_opcode = wr_pend & (wr_addr == BCE_REG_OPCODE);
  assign wr_count = wr_pend & (wr_addr == BCE_REG_COUNT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_phase & hwrite;
      wr_addr <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= BCE_CTRL_RST;
      sw_flags <= BCE_FLAGS_RST;
      sw_opcode <= BCE_OPC_RST;
    end else begin
      if (wr_ctrl) ctrl <= hwdata[1:0];
      if (wr_flags) sw_flags <= hwdata[3:0];
      if (wr_opcode) sw_opcode <= hwdata[7:0];
    end
  end

  assign sw_taken_q = sw_take ^ ctrl[BCE_CTRL_INV];

  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (rd_phase) begin
      unique case (haddr)
        BCE_REG_CTRL: next_hrdata = {30'h0000_0000, ctrl};
        BCE_REG_FLAGS: next_hrdata = {28'h000_0000, sw_flags};
        BCE_REG_OPCODE: next_hrdata = {24'h00_0000, sw_opcode};
        BCE_REG_RESULT: next_hrdata = {24'h00_0000, sw_sel, 2'h0,
          branch_valid, sw_taken_q};
        BCE_REG_COUNT: next_hrdata = {16'h0000, taken_count};
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule // bce_branch_eval

/* File: testbench/bce_branch_eval_sva.sv */
`timescale 1ns/10ps
module bce_branch_eval_sva (
  input logic hclk,
  input logic hresetn,
  input logic [7:0] opcode,
  input logic opcode_valid,
  input logic conditional_absolute_jump,
  input logic conditional_relative_jump,
  input logic flag_c,
  input logic flag_z,
  input logic flag_s,
  input logic flag_v,
  input logic branch_taken,
  input logic branch_valid
);
  wire rq = opcode_valid &
    (conditional_absolute_jump | conditional_relative_jump);
  wire [2:0] lo = opcode[6:4];
  wire iv = opcode[7];
  wire x = flag_s ^ flag_v;
  wire bt = branch_taken;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_v; rq |=> branch_valid; endproperty
  a_v: assert property (p_v) else $error("valid");
  property p_idle; !rq |=> !branch_valid && !bt; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_f; rq && opcode[7:4] == 4'h0 |=> !bt; endproperty
  a_f: assert property (p_f) else $error("never");
  property p_t; rq && opcode[7:4] == 4'h8 |=> bt; endproperty
  a_t: assert property (p_t) else $error("always");
  property p_lt; rq && lo == 3'h1 |=> bt == $past(x ^ iv); endproperty
  a_lt: assert property (p_lt) else $error("lt");
  property p_le;
    rq && lo == 3'h2 |=> bt == $past((flag_z | x) ^ iv);
  endproperty
  a_le: assert property (p_le) else $error("le");
  property p_ul;
    rq && lo == 3'h3 |=> bt == $past((flag_c | flag_z) ^ iv);
  endproperty
  a_ul: assert property (p_ul) else $error("ule");
  property p_vsz;
    rq && lo[2] && lo != 3'h7 |=>
      bt == $past((lo[0] ? flag_s : lo[1] ? flag_z : flag_v) ^ iv);
  endproperty
  a_vsz: assert property (p_vsz) else $error("vsz");
  property p_c; rq && lo == 3'h7 |=> bt == $past(flag_c ^ iv); endproperty
  a_c: assert property (p_c) else $error("carry");
endmodule // bce_branch_eval_sva

/* File: testbench/bce_pc_model.sv */
`timescale 1ns/10ps
module bce_pc_model (
  input logic hclk,
  input logic hresetn,
  input logic branch_valid,
  input logic branch_taken,
  output int jumps
);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) jumps <= 0;
    else if (branch_valid && branch_taken) jumps <= jumps + 1;
endmodule // bce_pc_model

/* File: testbench/bce_branch_eval_tb.sv */
`timescale 1ns/10ps
module bce_branch_eval_tb;
  import bce_pkg::*;
  logic hclk = 0, hresetn = 0, opcode_valid = 0, hsel = 0, hwrite = 0;
  logic conditional_absolute_jump = 0, conditional_relative_jump = 0;
  logic flag_c = 0, flag_z = 0, flag_s = 0, flag_v = 0, e;
  logic [7:0] opcode = '0, t;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = BCE_HSIZE_WORD;
  logic [31:0] haddr = '0, hwdata = '0, rd, jn = '0;
  wire branch_taken, branch_valid, hreadyout, hresp;
  wire hready = hreadyout;
  wire [31:0] hrdata;
  int num_errors = 0, tests_run = 0, jumps, i;
  always #5 hclk = ~hclk;
  bce_branch_eval dut (.*);
  bce_pc_model pcm (.*);
  task chk(string n, logic [31:0] x, y);
    tests_run++;
    if (x !== y) $display("Error %s exp %h got %h", n, x, y);
    num_errors += (x !== y);
  endtask
  task wt;
    for (i = 0; i < 9; i++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    num_errors += (i == 9);
    if (i == 9) complete_run;
  endtask
  task ahb(logic w, logic [31:0] a, d);
    @(posedge hclk);
    {hsel, haddr, htrans, hwrite} <= {1'b1, a, BCE_HTRANS_NONSEQ, w};
    wt;
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    wt;
    rd = hrdata;
    chk("hresp", '0, {31'h0000_0000, hresp});
    chk("hreadyout", 32'h1, {31'h0000_0000, hreadyout});
  endtask
  task br(logic [3:0] s, f, logic a, r);
    @(posedge hclk);
    {opcode, flag_v, flag_s, flag_z, flag_c} <= {s, 4'hA, f};
    {conditional_absolute_jump, conditional_relative_jump} <= {a, r};
    opcode_valid <= 1'b1;
    t = {f[0], f[1], f[2], f[3], f[0] | f[1], f[1] | f[2] ^ f[3],
      f[2] ^ f[3], 1'b0};
    e = (a | r) & (t[s[2:0]] ^ s[3]);
    jn += e;
    @(posedge hclk);
    opcode_valid <= 1'b0;
    #1;
    chk("valid", a | r, branch_valid);
    chk("taken", e, branch_taken);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b1, BCE_REG_CTRL, 32'h1);
    for (int k = 0; k < 1024; k++) begin
      br(k[7:4], k[3:0], k[8], k[9]);
    end
    $display("branch test done");
    ahb(1'b0, BCE_REG_COUNT, '0);
    chk("count", jn, rd);
    chk("jumps", jn, jumps);
    ahb(1'b0, 32'h40, '0);
    chk("unmapped", '0, rd);
    ahb(1'b1, BCE_REG_FLAGS, 32'h1);
    ahb(1'b1, BCE_REG_OPCODE, 32'h70);
    ahb(1'b0, BCE_REG_RESULT, '0);
    chk("result", 32'h71, rd);
    ahb(1'b1, BCE_REG_CTRL, 32'h3);
    ahb(1'b0, BCE_REG_RESULT, '0);
    chk("result_inv", 32'h70, rd);
    ahb(1'b0, BCE_REG_CTRL, '0);
    chk("ctrl", 32'h3, rd);
    ahb(1'b1, BCE_REG_COUNT, '0);
    ahb(1'b0, BCE_REG_COUNT, '0);
    chk("count_clr", '0, rd);
    $display("register test done");
    complete_run;
  end
endmodule // bce_branch_eval_tb
bind bce_branch_eval bce_branch_eval_sva sva (.*);
